// file: hw/fsc_consts.svh
// constants for the fuse and signature configuration store
`ifndef FSC_CONSTS_SVH
`define FSC_CONSTS_SVH
// fuse byte reset values as delivered (0 = programmed)
`define FSC_EXT_DEFAULT 8'hff
`define FSC_HIGH_DEFAULT 8'hd9
`define FSC_LOW_DEFAULT 8'h62
// trim value held during reset, before the calibration copy
`define FSC_TRIM_RESET 8'h80
// signature reads of unmapped addresses
`define FSC_SIG_UNMAPPED 8'hff
// synchroniser reset: mode low, lock unprogrammed (1), erase low
`define FSC_SYNC_IDLE 3'h2
// extended byte: only the brown-out level field is writable
`define FSC_EXT_LEVEL_MASK 8'h07
// high byte field positions
`define FSC_HI_EXT_RESET_DISABLE 7
`define FSC_HI_DEBUG_LINK_ENABLE 6
`define FSC_HI_SERIAL_PROG_ENABLE 5
`define FSC_HI_WATCHDOG_FORCED_ON 4
`define FSC_HI_EEPROM_KEEP 3
`define FSC_HI_BOOT_SIZE_B1 2
`define FSC_HI_BOOT_SIZE_B0 1
`define FSC_HI_RESET_VECTOR 0
// low byte field positions
`define FSC_LO_CLOCK_DIV_EIGHT 7
`define FSC_LO_CLOCK_OUT_ENABLE 6
`define FSC_LO_STARTUP_HI 5
`define FSC_LO_STARTUP_LO 4
`define FSC_LO_CLOCK_SRC_HI 3
`define FSC_LO_CLOCK_SRC_LO 0
// fuse select codes on the programming port
`define FSC_SEL_LOW 2'h0
`define FSC_SEL_HIGH 2'h1
`define FSC_SEL_EXT 2'h2
// signature space addresses
`define FSC_SIG_ID0 4'h0
`define FSC_SIG_ID1 4'h1
`define FSC_SIG_ID2 4'h2
`define FSC_SIG_SERIAL_BASE 4'h3
`define FSC_SERIAL_BYTES 9
// page organisation
`define FSC_FLASH_WORD_LSB 0
`define FSC_FLASH_WORD_MSB 5
`define FSC_FLASH_PAGE_MSB 13
`define FSC_EE_BYTE_MSB 1
`define FSC_EE_PAGE_MSB 9
`endif

// file: hw/fsc_pkg.sv
// types for the fuse and signature configuration store
package fsc_pkg;
  // programming path that carries a fuse write
  typedef enum logic {
    FSC_PATH_PARALLEL,
    FSC_PATH_SERIAL
  } fsc_path_t;
  // session state of the latching logic
  typedef enum logic [1:0] {
    FSC_ST_POWERUP,
    FSC_ST_NORMAL,
    FSC_ST_PROG
  } fsc_state_t;
endpackage

// file: hw/fsc_store.sv
// fuse store with deferred latching, signature space and page address split
//
// Contract
// - every fuse reads 0 when programmed, 1 when unprogrammed, on all paths
// - extended byte: brown-out level in bits 2:0, bits 7:3 fixed at 1
// - high byte order: reset disable, debug, serial prog, watchdog, keep, boot size, vector
// - high default: serial programming and both boot-size bits programmed, rest unprogrammed
// - serial-programming-enable fuse cannot be changed over the serial path
// - eeprom-keep fuse programmed means chip erase spares the eeprom
// - low byte: div8, clock out, two start-up bits, four clock source bits
// - low default: internal rc 8 MHz, longest start-up, divide by eight programmed
// - programmed clock-out fuse drives system clock onto port b bit 0
// - chip erase never changes any fuse bit
// - lock bit one programmed refuses every fuse change
// - working copies latched on programming entry; changes wait until exit
// - eeprom-keep fuse takes effect at once when programmed
// - working copies also latched at power-up in normal mode
// - three identity bytes at signature addresses 0, 1, 2, readable even locked
// - calibration byte at high byte of address 0 copied to trim on reset
// - nine-byte serial number readable from the signature space
// - flash: 256 pages of 64 words, word pc[5:0], page pc[13:6]
// - eeprom: 256 pages of 4 bytes, byte eea[1:0], page eea[9:2]
`include "fsc_consts.svh"

module fsc_store #(
  parameter logic [7:0] SIG_ID0 = 8'h5a, // arbitrary identity value
  parameter logic [7:0] SIG_ID1 = 8'ha5, // arbitrary identity value
  parameter logic [7:0] SIG_ID2 = 8'h3c, // arbitrary identity value
  parameter logic [7:0] CAL_VALUE = 8'h80,
  parameter logic [71:0] SERIAL_VALUE = 72'h0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic prog_mode,
  input wire logic fuse_wr,
  input wire fsc_pkg::fsc_path_t fuse_path,
  input wire logic [1:0] fuse_sel,
  input wire logic [7:0] fuse_wdata,
  input wire logic lock_bit_one,
  input wire logic chip_erase,
  input wire logic [3:0] sig_addr,
  input wire logic sig_hi,
  input wire logic [13:0] prog_counter,
  input wire logic [9:0] eeprom_addr,
  output logic [7:0] ext_fuse_rd,
  output logic [7:0] high_fuse_rd,
  output logic [7:0] low_fuse_rd,
  output logic [7:0] sig_rdata,
  output logic [7:0] osc_trim_register,
  output logic [7:0] ext_working,
  output logic [7:0] high_working,
  output logic [7:0] low_working,
  output logic eeprom_erase_en,
  output logic clock_out_on_pb0,
  output logic [5:0] flash_word_in_page,
  output logic [7:0] flash_page_index,
  output logic [1:0] eeprom_byte_in_page,
  output logic [7:0] eeprom_page_index
);
  import fsc_pkg::*;

  // ----------------------------------------
  // synchronisers for the pin-level inputs
  // ----------------------------------------
  logic [2:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
  logic prog_s, lock_s, erase_s;

  always_comb begin
    nxt_sync1 = {prog_mode, lock_bit_one, chip_erase};
    nxt_sync2 = sync1_ff;
  end

  // both stages reset to the idle pin levels; a lock stage reset to 0 would read as a
  // programmed lock and drop writes in the first cycles after reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_ff <= `FSC_SYNC_IDLE;
      sync2_ff <= `FSC_SYNC_IDLE;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  // only the second stage is read; bit order is mode, lock, erase
  assign prog_s = sync2_ff[2];
  assign lock_s = sync2_ff[1];
  assign erase_s = sync2_ff[0];

  // ----------------------------------------
  // non-volatile fuse storage
  // ----------------------------------------
  // stored as read, 0 = programmed, so every read path is a plain copy
  // a write lands on the edge that takes it and shows on the read ports one edge later
  logic [7:0] ext_nv_ff, high_nv_ff, low_nv_ff;
  logic [7:0] nxt_ext_nv, nxt_high_nv, nxt_low_nv;
  logic wr_ok;

  // lock bit one is active low (0 = programmed); chip erase has no path here
  assign wr_ok = fuse_wr && lock_s;

  always_comb begin
    nxt_ext_nv = ext_nv_ff;
    nxt_high_nv = high_nv_ff;
    nxt_low_nv = low_nv_ff;
    if (wr_ok) begin
      unique case (fuse_sel)
        `FSC_SEL_EXT: nxt_ext_nv = fuse_wdata | ~`FSC_EXT_LEVEL_MASK;
        `FSC_SEL_HIGH: begin
          nxt_high_nv = fuse_wdata;
          // serial path keeps the serial enable fuse untouched
          if (fuse_path == FSC_PATH_SERIAL) begin
            nxt_high_nv[`FSC_HI_SERIAL_PROG_ENABLE] = high_nv_ff[`FSC_HI_SERIAL_PROG_ENABLE];
          end
        end
        `FSC_SEL_LOW: nxt_low_nv = fuse_wdata;
        default: ; // unused select code is ignored
      endcase
    end
  end

  // reset models the delivered state of the fuse array
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ext_nv_ff <= `FSC_EXT_DEFAULT;
      high_nv_ff <= `FSC_HIGH_DEFAULT;
      low_nv_ff <= `FSC_LOW_DEFAULT;
    end else begin
      ext_nv_ff <= nxt_ext_nv;
      high_nv_ff <= nxt_high_nv;
      low_nv_ff <= nxt_low_nv;
    end
  end

  // ----------------------------------------
  // working copies and latch events
  // ----------------------------------------
  fsc_state_t state_ff, nxt_state;
  logic [7:0] nxt_ext_w, nxt_high_w, nxt_low_w;
  logic nxt_keep_now, keep_now_ff;
  logic latch;

  // latch events: the first cycle after reset, and each entry to or exit from
  // programming mode as seen through the synchroniser; between them the working
  // copies only recirculate, whatever the storage does
  always_comb begin
    nxt_state = state_ff;
    latch = 1'b0;
    unique case (state_ff)
      FSC_ST_POWERUP: begin
        latch = 1'b1;
        // power-up always goes to normal mode, as the synchroniser still reads its idle level; a pin already up enters the session from there
        nxt_state = prog_s ? FSC_ST_PROG : FSC_ST_NORMAL;
      end
      FSC_ST_NORMAL: begin
        if (prog_s) begin
          latch = 1'b1;
          nxt_state = FSC_ST_PROG;
        end
      end
      FSC_ST_PROG: begin
        // apart from the keep fuse, new values only reach the system after leaving programming mode
        if (!prog_s) begin
          latch = 1'b1;
          nxt_state = FSC_ST_NORMAL;
        end
      end
    endcase
    nxt_ext_w = latch ? ext_nv_ff : ext_working;
    nxt_high_w = latch ? high_nv_ff : high_working;
    nxt_low_w = latch ? low_nv_ff : low_working;
    // keep fuse bypasses deferral: it follows the storage directly
    // taken from the next storage value, so it moves in the same edge as the write
    nxt_keep_now = nxt_high_nv[`FSC_HI_EEPROM_KEEP];
  end

  // working copies reset to the delivered values so the system sees sane fuses even
  // before the power-up latch has run
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= FSC_ST_POWERUP;
      ext_working <= `FSC_EXT_DEFAULT;
      high_working <= `FSC_HIGH_DEFAULT;
      low_working <= `FSC_LOW_DEFAULT;
      keep_now_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      ext_working <= nxt_ext_w;
      high_working <= nxt_high_w;
      low_working <= nxt_low_w;
      keep_now_ff <= nxt_keep_now;
    end
  end

  // ----------------------------------------
  // read paths, signature space and outputs
  // ----------------------------------------
  // every output below is the registered copy of one nxt_ value, so the pins never
  // see a combinational glitch from the address decode or the fuse storage
  logic [7:0] nxt_sig, nxt_trim;
  logic [7:0] nxt_ext_rd, nxt_high_rd, nxt_low_rd;
  logic nxt_erase_en, nxt_clock_out;
  logic [5:0] nxt_flash_word;
  logic [7:0] nxt_flash_page;
  logic [1:0] nxt_ee_byte;
  logic [7:0] nxt_ee_page;
  logic [3:0] serial_idx;
  logic [7:0] serial_byte [`FSC_SERIAL_BYTES];

  // serial number bytes, byte 0 taken from the lowest eight bits of the parameter
  genvar gi;
  generate
    for (gi = 0; gi < `FSC_SERIAL_BYTES; gi++) begin : g_serial
      assign serial_byte[gi] = SERIAL_VALUE[gi*8 +: 8];
    end
  endgenerate

  // offset into the serial number window; it wraps below the base address,
  // which the range test in the decode then rejects
  assign serial_idx = sig_addr - `FSC_SIG_SERIAL_BASE;

  // signature decode; identity reads ignore the lock state on purpose so that a
  // locked part can still be recognised by the programmer
  always_comb begin
    nxt_sig = `FSC_SIG_UNMAPPED;
    if (sig_hi) begin
      // only address 0 carries a high byte, the calibration value
      if (sig_addr == `FSC_SIG_ID0) begin
        nxt_sig = CAL_VALUE;
      end
    end else if (sig_addr == `FSC_SIG_ID0) begin
      nxt_sig = SIG_ID0;
    end else if (sig_addr == `FSC_SIG_ID1) begin
      nxt_sig = SIG_ID1;
    end else if (sig_addr == `FSC_SIG_ID2) begin
      nxt_sig = SIG_ID2;
    end else if (sig_addr >= `FSC_SIG_SERIAL_BASE && serial_idx < 4'(`FSC_SERIAL_BYTES)) begin
      nxt_sig = serial_byte[serial_idx];
    end
  end

  // trim: loaded from the calibration byte in the first cycle after every reset,
  // then held; later tuning of the trim lives outside this block
  always_comb begin
    nxt_trim = osc_trim_register;
    if (state_ff == FSC_ST_POWERUP) begin
      nxt_trim = CAL_VALUE;
    end
  end

  // fuse read paths: the storage already holds the read polarity, 0 = programmed,
  // so serial and parallel reads see the same plain copy
  always_comb begin
    nxt_ext_rd = ext_nv_ff;
    nxt_high_rd = high_nv_ff;
    nxt_low_rd = low_nv_ff;
  end

  // chip erase reaches the eeprom only while the keep fuse is unprogrammed; the keep
  // value is the immediate one, not the latched working copy
  // clock output follows the working low byte, so a fuse write inside a session does
  // not start or stop the clock pin until the session ends
  always_comb begin
    nxt_erase_en = erase_s && keep_now_ff;
    nxt_clock_out = !low_working[`FSC_LO_CLOCK_OUT_ENABLE];
  end

  // page address split; pure wiring, registered so the outputs come from flops
  always_comb begin
    nxt_flash_word = prog_counter[`FSC_FLASH_WORD_MSB:`FSC_FLASH_WORD_LSB];
    nxt_flash_page = prog_counter[`FSC_FLASH_PAGE_MSB:`FSC_FLASH_WORD_MSB+1];
    nxt_ee_byte = eeprom_addr[`FSC_EE_BYTE_MSB:0];
    nxt_ee_page = eeprom_addr[`FSC_EE_PAGE_MSB:`FSC_EE_BYTE_MSB+1];
  end

  // output registers; fuse reads reset to the delivered state so nothing downstream
  // sees a fuse value other than the delivered one before the first edge
  // the read ports lag the storage by one edge: readers allow two edges after a write
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      osc_trim_register <= `FSC_TRIM_RESET;
      ext_fuse_rd <= `FSC_EXT_DEFAULT;
      high_fuse_rd <= `FSC_HIGH_DEFAULT;
      low_fuse_rd <= `FSC_LOW_DEFAULT;
      sig_rdata <= `FSC_SIG_UNMAPPED;
      eeprom_erase_en <= 1'b0;
      clock_out_on_pb0 <= 1'b0;
      flash_word_in_page <= 6'h0;
      flash_page_index <= 8'h0;
      eeprom_byte_in_page <= 2'h0;
      eeprom_page_index <= 8'h0;
    end else begin
      osc_trim_register <= nxt_trim;
      ext_fuse_rd <= nxt_ext_rd;
      high_fuse_rd <= nxt_high_rd;
      low_fuse_rd <= nxt_low_rd;
      sig_rdata <= nxt_sig;
      eeprom_erase_en <= nxt_erase_en;
      clock_out_on_pb0 <= nxt_clock_out;
      flash_word_in_page <= nxt_flash_word;
      flash_page_index <= nxt_flash_page;
      eeprom_byte_in_page <= nxt_ee_byte;
      eeprom_page_index <= nxt_ee_page;
    end
  end
endmodule

// file: testbench/fsc_store_sva.sv
// concurrent checks on the fuse and signature store ports
module fsc_store_sva #(
  parameter logic [7:0] SIG_ID0 = 8'h5a, // arbitrary identity value
  parameter logic [7:0] CAL_VALUE = 8'h80
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic prog_mode,
  input wire logic fuse_wr,
  input wire fsc_pkg::fsc_path_t fuse_path,
  input wire logic [1:0] fuse_sel,
  input wire logic lock_bit_one,
  input wire logic chip_erase,
  input wire logic [3:0] sig_addr,
  input wire logic sig_hi,
  input wire logic [13:0] prog_counter,
  input wire logic [9:0] eeprom_addr,
  input wire logic [7:0] ext_fuse_rd,
  input wire logic [7:0] high_fuse_rd,
  input wire logic [7:0] low_fuse_rd,
  input wire logic [7:0] sig_rdata,
  input wire logic [7:0] osc_trim_register,
  input wire logic [7:0] high_working,
  input wire logic [7:0] low_working,
  input wire logic eeprom_erase_en,
  input wire logic clock_out_on_pb0,
  input wire logic [5:0] flash_word_in_page,
  input wire logic [7:0] flash_page_index,
  input wire logic [1:0] eeprom_byte_in_page,
  input wire logic [7:0] eeprom_page_index
);
  import fsc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // --------------------------------------------------------------
  // named steps
  // --------------------------------------------------------------
  // lock pin held long enough to cover the two-flop sync and write latency
  sequence locked_s;
    (!lock_bit_one)[*6];
  endsequence
  sequence keep_prog_s;
    !high_fuse_rd[3] && !$past(high_fuse_rd[3], 2);
  endsequence
  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  ext_fixed_a: assert property (&ext_fuse_rd[7:3]) else $error("extended fuse top bits not one");
  trim_cal_a: assert property ($past(resetn) |-> osc_trim_register == CAL_VALUE)
    else $error("trim does not hold calibration byte");
  id_read_a: assert property ($past(resetn) && $past(sig_addr) == 4'h0 && !$past(sig_hi) |-> sig_rdata == SIG_ID0)
    else $error("identity byte zero wrong");
  flash_split_a: assert property ($past(resetn) |-> {flash_page_index, flash_word_in_page} == $past(prog_counter))
    else $error("flash page split wrong");
  ee_split_a: assert property ($past(resetn) |-> {eeprom_page_index, eeprom_byte_in_page} == $past(eeprom_addr))
    else $error("eeprom page split wrong");
  lock_hold_a: assert property (locked_s |-> $stable({ext_fuse_rd, high_fuse_rd, low_fuse_rd}))
    else $error("fuse changed while locked");
  serial_keep_a: assert property (fuse_wr && fuse_path == FSC_PATH_SERIAL && fuse_sel == 2'h1
    |-> ##2 $stable(high_fuse_rd[5])) else $error("serial path changed programming enable");
  work_hold_a: assert property ($stable(prog_mode)[*8] |-> $stable({high_working, low_working}))
    else $error("working copy moved between latch events");
  keep_now_a: assert property (keep_prog_s |-> !eeprom_erase_en) else $error("eeprom erased despite keep");
  erase_on_a: assert property (chip_erase[*5] ##0 high_fuse_rd[3] && $past(high_fuse_rd[3], 2) |-> eeprom_erase_en)
    else $error("eeprom not erased with flash");
  clkout_a: assert property ($stable(low_working)[*2] |-> clock_out_on_pb0 == !low_working[6])
    else $error("clock output enable mismatch");
endmodule
bind fsc_store fsc_store_sva #(.SIG_ID0(SIG_ID0), .CAL_VALUE(CAL_VALUE)) chk_i (.clk, .resetn, .prog_mode, .fuse_wr,
  .fuse_path, .fuse_sel, .lock_bit_one, .chip_erase, .sig_addr, .sig_hi, .prog_counter, .eeprom_addr, .ext_fuse_rd,
  .high_fuse_rd, .low_fuse_rd, .sig_rdata, .osc_trim_register, .high_working, .low_working, .eeprom_erase_en,
  .clock_out_on_pb0, .flash_word_in_page, .flash_page_index, .eeprom_byte_in_page, .eeprom_page_index);

// file: testbench/fsc_prog_model.sv
// programmer model driving the fuse write and mode pins of the store
module fsc_prog_model (
  input wire logic clk,
  output logic prog_mode,
  output logic fuse_wr,
  output fsc_pkg::fsc_path_t fuse_path,
  output logic [1:0] fuse_sel,
  output logic [7:0] fuse_wdata,
  output logic lock_bit_one,
  output logic chip_erase
);
  timeunit 1ns;
  timeprecision 1ns;
  import fsc_pkg::*;
  // idle pins at time zero, lock left unprogrammed until fuses are done
  initial begin
    {prog_mode, fuse_wr, chip_erase, lock_bit_one} = 4'h1;
    fuse_path = FSC_PATH_PARALLEL;
    fuse_sel = 2'h3;
    fuse_wdata = 8'h00;
  end
  // one-cycle write pulse; the bench also issues one after the lock is set
  task automatic wr(input fsc_path_t p, input logic [1:0] s, input logic [7:0] d);
    @(negedge clk);
    fuse_path = p;
    fuse_sel = s;
    fuse_wdata = d;
    fuse_wr = 1'b1;
    @(negedge clk);
    fuse_wr = 1'b0;
    fuse_wdata = ~d; // released data never repeats the last byte
  endtask
  // level pins: mode, chip erase, lock (0 = programmed)
  task automatic pins(input logic m, input logic e, input logic l);
    @(negedge clk);
    {prog_mode, chip_erase, lock_bit_one} = {m, e, l};
  endtask
endmodule

// file: testbench/fuse_signature_config_store_tb_top.sv
// self-checking bench for the fuse and signature store
module fuse_signature_config_store_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fsc_pkg::*;
  logic clk, resetn, prog_mode, fuse_wr, lock_bit_one, chip_erase, sig_hi, eeprom_erase_en, clock_out_on_pb0;
  fsc_path_t fuse_path;
  logic [1:0] fuse_sel, eeprom_byte_in_page;
  logic [3:0] sig_addr;
  logic [5:0] flash_word_in_page;
  logic [7:0] fuse_wdata, ext_fuse_rd, high_fuse_rd, low_fuse_rd, sig_rdata, osc_trim_register;
  logic [7:0] ext_working, high_working, low_working, flash_page_index, eeprom_page_index;
  logic [13:0] prog_counter;
  logic [9:0] eeprom_addr;
  int failures = 0;
  int tests_run = 0;
  // calibration differs from the trim reset value so the copy is visible
  localparam logic [7:0] CAL_BYTE = 8'h6b;
  // serial byte i holds i+1 so the byte order is visible
  localparam logic [71:0] SERIAL_NUM = 72'h090807060504030201;
  fsc_store #(.CAL_VALUE(CAL_BYTE), .SERIAL_VALUE(SERIAL_NUM)) dut (.clk, .resetn, .prog_mode, .fuse_wr,
    .fuse_path, .fuse_sel, .fuse_wdata, .lock_bit_one,
    .chip_erase, .sig_addr, .sig_hi, .prog_counter, .eeprom_addr, .ext_fuse_rd, .high_fuse_rd, .low_fuse_rd,
    .sig_rdata, .osc_trim_register, .ext_working, .high_working, .low_working, .eeprom_erase_en,
    .clock_out_on_pb0, .flash_word_in_page, .flash_page_index, .eeprom_byte_in_page, .eeprom_page_index);
  fsc_prog_model pm (.clk, .prog_mode, .fuse_wr, .fuse_path, .fuse_sel, .fuse_wdata, .lock_bit_one, .chip_erase);
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  initial begin
    {resetn, sig_hi, sig_addr, prog_counter, eeprom_addr} = '0;
    cyc(5);
    resetn = 1'b1;
    cyc(2);
    chk(ext_fuse_rd, 8'hff);
    chk(high_fuse_rd, 8'hd9);
    chk(low_fuse_rd, 8'h62);
    chk(low_working, 8'h62);
    chk(osc_trim_register, CAL_BYTE);
    chk({7'h0, clock_out_on_pb0}, 8'h00);
    // identity, serial number and an unmapped address
    for (int a = 0; a < 13; a++) begin
      sig_addr = a[3:0];
      cyc(1);
      chk(sig_rdata, a == 0 ? 8'h5a : a == 1 ? 8'ha5 : a == 2 ? 8'h3c : a < 12 ? 8'(a - 2) : 8'hff);
    end
    sig_addr = 4'h0;
    sig_hi = 1'b1;
    prog_counter = 14'h3fc5;
    eeprom_addr = 10'h2b6;
    cyc(1);
    chk(sig_rdata, CAL_BYTE);
    chk(flash_page_index, 8'hff);
    chk({2'h0, flash_word_in_page}, 8'h05);
    chk(eeprom_page_index, 8'had);
    chk({6'h0, eeprom_byte_in_page}, 8'h02);
    // programming session with chip erase held throughout
    pm.pins(1'b1, 1'b1, 1'b1);
    cyc(4);
    chk({7'h0, eeprom_erase_en}, 8'h01);
    chk(high_fuse_rd, 8'hd9);
    pm.wr(FSC_PATH_PARALLEL, 2'h0, 8'h22);
    pm.wr(FSC_PATH_PARALLEL, 2'h1, 8'hd1);
    pm.wr(FSC_PATH_SERIAL, 2'h1, 8'hf1);
    pm.wr(FSC_PATH_PARALLEL, 2'h2, 8'h00);
    cyc(3);
    chk(low_fuse_rd, 8'h22);
    chk(high_fuse_rd, 8'hd1);
    chk(ext_fuse_rd, 8'hf8);
    chk({7'h0, eeprom_erase_en}, 8'h00);
    chk(low_working, 8'h62);
    pm.pins(1'b0, 1'b0, 1'b1);
    cyc(4);
    chk(low_working, 8'h22);
    chk(high_working, 8'hd1);
    chk(ext_working, 8'hf8);
    chk({7'h0, clock_out_on_pb0}, 8'h01);
    // locked: write refused, identity still readable
    pm.pins(1'b0, 1'b0, 1'b0);
    cyc(3);
    pm.wr(FSC_PATH_PARALLEL, 2'h0, 8'hff);
    sig_hi = 1'b0;
    sig_addr = 4'h1;
    cyc(3);
    chk(low_fuse_rd, 8'h22);
    chk(sig_rdata, 8'ha5);
    // second reset in mid-run: trim drops to its reset value, then reloads
    resetn = 1'b0;
    cyc(1);
    chk(osc_trim_register, 8'h80);
    cyc(4);
    resetn = 1'b1;
    cyc(2);
    chk(osc_trim_register, CAL_BYTE);
    chk(low_working, 8'h62);
    close_out();
  end
endmodule
